/* hdl/cpsr_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module cpsr_decode
	import cpsr_pkg::*;
(
	input  wire logic        clk_sys,         // System clock, 20 MHz
	input  wire logic        reset_n,         // Asynchronous reset, active low
	input  wire logic        inst_valid,      // Instruction words present
	input  wire logic [15:0] inst_op,         // Operation word
	input  wire logic [15:0] inst_ext,        // Word after the operation word
	input  wire logic [31:0] inst_pc,         // Address of the operation word
	input  wire logic        supervisor,      // Supervisor state
	output logic             inst_ready,      // Decoder can take an instruction
	output logic             cp_req,          // Command pulse to coprocessor
	output cpsr_op_e         cp_op,           // Kind of command
	output logic [2:0]       cp_sel,          // Coprocessor select field
	output logic [5:0]       cp_cond,         // Condition passed on
	input  wire logic        cp_resp_valid,   // Coprocessor directive present
	input  wire logic        cp_resp_true,    // Condition result
	input  wire logic        cp_resp_again,   // Format word says come again
	input  wire logic [7:0]  cp_resp_len,     // State words to move
	output logic             cp_wr_valid,     // Restore word to coprocessor
	output logic [31:0]      cp_wr_data,      // Restore word
	input  wire logic        cp_word_valid,   // Save word from coprocessor
	input  wire logic [31:0] cp_word_data,    // Save word
	output logic             cp_rd_ready,     // Decoder takes save words
	output logic             mem_rd_req,      // Read next restore word
	input  wire logic        mem_rd_valid,    // Restore word from memory
	input  wire logic [31:0] mem_rd_data,     // Restore word from memory
	output logic             mem_wr_valid,    // Save word to memory
	output logic [31:0]      mem_wr_data,     // Save word to memory
	output logic [2:0]       ea_mode,         // Latched address mode
	output logic [2:0]       ea_reg,          // Latched address register
	output logic             dest_wr,         // Destination byte write pulse
	output logic [7:0]       dest_byte,       // Destination byte
	output logic             exc_req,         // Exception request pulse
	output logic [7:0]       exc_vector,      // Exception vector number
	output logic [31:0]      next_pc,         // Address of next instruction
	output logic             inst_done,       // Normal completion pulse
	output logic             irq_inhibit      // Hold off interrupt service
);
	cpsr_state_e state_reg;
	cpsr_op_e    op_reg, dec_op;
	logic [2:0]  sel_reg, ea_mode_reg, ea_reg_reg;
	logic [5:0]  cond_reg;
	logic [31:0] pc_next_reg, cp_wr_data_reg, mem_wr_data_reg;
	logic [7:0]  count_reg, dest_byte_reg, exc_vector_reg;
	logic        cp_req_reg, cp_wr_valid_reg, mem_wr_valid_reg, dest_wr_reg;
	logic        exc_req_reg, done_reg, inhibit_reg;

	logic [2:0]  op_type, trap_operand_form, op_rg;
	logic        abs_ok, dec_known, dec_legal, dec_priv;
	logic [1:0]  trap_words;
	logic        take, resp, rd_beat, wr_beat, last_beat;

	assign op_type = inst_op[CPSR_TYPE_LSB +: 3];
	assign trap_operand_form = inst_op[CPSR_MODE_LSB +: 3];
	assign op_rg   = inst_op[2:0];
	assign abs_ok  = (trap_operand_form == CPSR_EA_EXT) &&
		(op_rg == CPSR_EXT_ABSW || op_rg == CPSR_EXT_ABSL);

	always_comb begin
		dec_op     = CPSR_OP_SET;
		dec_known  = 1'b0;
		dec_legal  = 1'b0;
		trap_words = 2'h0;
		if (inst_op[15:12] == CPSR_LINE_CODE) begin
			case (op_type)
				CPSR_TYPE_REST: begin
					dec_op    = CPSR_OP_RESTORE;
					dec_known = 1'b1;
					dec_legal = abs_ok || trap_operand_form == CPSR_EA_IND ||
						trap_operand_form == CPSR_EA_POST || trap_operand_form == CPSR_EA_IDX;
				end
				CPSR_TYPE_SAVE: begin
					dec_op    = CPSR_OP_SAVE;
					dec_known = 1'b1;
					dec_legal = abs_ok || trap_operand_form == CPSR_EA_IND ||
						trap_operand_form == CPSR_EA_PRE || trap_operand_form == CPSR_EA_DISP ||
						trap_operand_form == CPSR_EA_IDX;
				end
				CPSR_TYPE_COND: begin
					dec_known = 1'b1;
					if (trap_operand_form == CPSR_EA_EXT && !abs_ok) begin
						// Mode 111 with a non-absolute register is the trap form
						dec_op = CPSR_OP_TRAP;
						case (op_rg)
							CPSR_FORM_ONE: begin
								dec_legal  = 1'b1;
								trap_words = 2'h1;
							end
							CPSR_FORM_TWO: begin
								dec_legal  = 1'b1;
								trap_words = 2'h2;
							end
							CPSR_FORM_NONE: dec_legal = 1'b1;
							default: dec_legal = 1'b0;
						endcase
					end else begin
						dec_op    = CPSR_OP_SET;
						dec_legal = trap_operand_form != CPSR_EA_AREG;
					end
				end
				default: dec_known = 1'b0;
			endcase
		end
	end

	assign dec_priv   = dec_known && dec_op == CPSR_OP_RESTORE && !supervisor;
	assign inst_ready = state_reg == CPSR_ST_IDLE;
	assign take       = inst_valid && inst_ready;
	assign resp       = state_reg == CPSR_ST_WAIT && cp_resp_valid;
	assign mem_rd_req = state_reg == CPSR_ST_XFER && op_reg == CPSR_OP_RESTORE;
	assign cp_rd_ready = state_reg == CPSR_ST_XFER && op_reg == CPSR_OP_SAVE;
	assign rd_beat    = mem_rd_req && mem_rd_valid;
	assign wr_beat    = cp_rd_ready && cp_word_valid;
	assign last_beat  = (rd_beat || wr_beat) && count_reg == 8'h01;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= CPSR_ST_IDLE;
		end else begin
			case (state_reg)
				CPSR_ST_IDLE: begin
					if (take && dec_known && dec_legal && !dec_priv) begin
						state_reg <= CPSR_ST_WAIT;
					end
				end
				CPSR_ST_WAIT: begin
					if (resp && !(op_reg == CPSR_OP_RESTORE && cp_resp_again)) begin
						state_reg <= ((op_reg == CPSR_OP_RESTORE || op_reg == CPSR_OP_SAVE) &&
							cp_resp_len != CPSR_COUNT_RST) ? CPSR_ST_XFER : CPSR_ST_IDLE;
					end
				end
				CPSR_ST_XFER: begin
					if (last_beat) begin
						state_reg <= CPSR_ST_IDLE;
					end
				end
				default: state_reg <= CPSR_ST_IDLE;
			endcase
		end
	end

	// Instruction fields held for the coprocessor dialogue
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			op_reg      <= CPSR_OP_RESTORE;
			sel_reg     <= 3'h0;
			cond_reg    <= 6'h00;
			ea_mode_reg <= 3'h0;
			ea_reg_reg  <= 3'h0;
			pc_next_reg <= CPSR_WORD_RST;
		end else if (take) begin
			op_reg      <= dec_op;
			sel_reg     <= inst_op[CPSR_SEL_LSB +: 3];
			cond_reg    <= (dec_op == CPSR_OP_SET || dec_op == CPSR_OP_TRAP) ?
				inst_ext[CPSR_COND_WIDTH-1:0] : 6'h00;
			ea_mode_reg <= trap_operand_form;
			ea_reg_reg  <= op_rg;
			// Operand words belong to the trap handler and are only stepped over
			pc_next_reg <= inst_pc + CPSR_BASE_BYTES + {29'h0, trap_words, 1'b0};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cp_req_reg <= 1'b0;
		end else begin
			// A come-again answer asks for the restore command once more
			cp_req_reg <= (take && dec_known && dec_legal && !dec_priv) ||
				(resp && op_reg == CPSR_OP_RESTORE && cp_resp_again);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			inhibit_reg <= 1'b0;
		end else if (resp && op_reg == CPSR_OP_RESTORE && cp_resp_again) begin
			inhibit_reg <= 1'b1;
		end else if (state_reg == CPSR_ST_IDLE) begin
			inhibit_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= CPSR_COUNT_RST;
		end else if (resp) begin
			count_reg <= cp_resp_len;
		end else if (rd_beat || wr_beat) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	// State words pass through one register stage in either direction
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cp_wr_valid_reg  <= 1'b0;
			cp_wr_data_reg   <= CPSR_WORD_RST;
			mem_wr_valid_reg <= 1'b0;
			mem_wr_data_reg  <= CPSR_WORD_RST;
		end else begin
			cp_wr_valid_reg  <= rd_beat;
			mem_wr_valid_reg <= wr_beat;
			cp_wr_data_reg   <= rd_beat ? mem_rd_data : cp_wr_data_reg;
			mem_wr_data_reg  <= wr_beat ? cp_word_data : mem_wr_data_reg;
		end
	end

	// No path here writes condition codes: none of the four touch them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dest_wr_reg    <= 1'b0;
			dest_byte_reg  <= 8'h00;
			exc_req_reg    <= 1'b0;
			exc_vector_reg <= 8'h00;
			done_reg       <= 1'b0;
		end else begin
			dest_wr_reg <= 1'b0;
			exc_req_reg <= 1'b0;
			done_reg    <= 1'b0;
			if (take && !dec_known) begin
				exc_req_reg    <= 1'b1;
				exc_vector_reg <= CPSR_VEC_UNIMPL;
			end else if (take && dec_priv) begin
				// Privilege is checked before the address mode
				exc_req_reg    <= 1'b1;
				exc_vector_reg <= CPSR_VEC_PRIV;
			end else if (take && !dec_legal) begin
				exc_req_reg    <= 1'b1;
				exc_vector_reg <= CPSR_VEC_ILLEGAL;
			end else if (resp && op_reg == CPSR_OP_SET) begin
				dest_wr_reg   <= 1'b1;
				dest_byte_reg <= cp_resp_true ? 8'hff : 8'h00;
				done_reg      <= 1'b1;
			end else if (resp && op_reg == CPSR_OP_TRAP && cp_resp_true) begin
				exc_req_reg    <= 1'b1;
				exc_vector_reg <= CPSR_VEC_CPTRAP;
			end else if (resp && op_reg == CPSR_OP_TRAP) begin
				done_reg <= 1'b1;
			end else if (resp && !cp_resp_again && cp_resp_len == CPSR_COUNT_RST) begin
				done_reg <= 1'b1;
			end else if (last_beat) begin
				done_reg <= 1'b1;
			end
		end
	end

	assign cp_req      = cp_req_reg;
	assign cp_op       = op_reg;
	assign cp_sel      = sel_reg;
	assign cp_cond     = cond_reg;
	assign cp_wr_valid = cp_wr_valid_reg;
	assign cp_wr_data  = cp_wr_data_reg;
	assign mem_wr_valid = mem_wr_valid_reg;
	assign mem_wr_data = mem_wr_data_reg;
	assign ea_mode     = ea_mode_reg;
	assign ea_reg      = ea_reg_reg;
	assign dest_wr     = dest_wr_reg;
	assign dest_byte   = dest_byte_reg;
	assign exc_req     = exc_req_reg;
	assign exc_vector  = exc_vector_reg;
	assign next_pc     = pc_next_reg;
	assign inst_done   = done_reg;
	assign irq_inhibit = inhibit_reg;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	chk_restore_priv: assert property (take && dec_known && dec_op == CPSR_OP_RESTORE &&
		!supervisor |=> exc_req && exc_vector == CPSR_VEC_PRIV && !cp_req && inst_ready)
		else $error("restore outside supervisor not refused");
	chk_restore_sel: assert property (take && dec_op == CPSR_OP_RESTORE && dec_legal &&
		supervisor |=> cp_req && cp_op == CPSR_OP_RESTORE && cp_sel == $past(inst_op[11:9]))
		else $error("restore not sent to selected coprocessor");
	chk_restore_ea: assert property (take && inst_op[15:12] == CPSR_LINE_CODE &&
		op_type == CPSR_TYPE_REST && trap_operand_form == CPSR_EA_PRE && supervisor
		|=> exc_req && exc_vector == CPSR_VEC_ILLEGAL)
		else $error("restore predecrement not refused");
	chk_come_again: assert property (resp && op_reg == CPSR_OP_RESTORE && cp_resp_again
		|=> irq_inhibit && cp_req && state_reg == CPSR_ST_WAIT)
		else $error("come again did not hold off interrupts");
	chk_save_word: assert property (wr_beat
		|=> mem_wr_valid && mem_wr_data == $past(cp_word_data) ##1 !mem_wr_valid || $past(wr_beat))
		else $error("save word not written out");
	chk_save_ea: assert property (take && inst_op[15:12] == CPSR_LINE_CODE &&
		op_type == CPSR_TYPE_SAVE && trap_operand_form == CPSR_EA_POST
		|=> exc_req && exc_vector == CPSR_VEC_ILLEGAL && !cp_req)
		else $error("save postincrement not refused");
	chk_set_byte: assert property (resp && op_reg == CPSR_OP_SET
		|=> dest_wr && inst_done && dest_byte == {8{$past(cp_resp_true)}})
		else $error("set byte does not follow condition");
	chk_cond_word: assert property (take && dec_known && dec_legal && !dec_priv &&
		(dec_op == CPSR_OP_SET || dec_op == CPSR_OP_TRAP) |=> cp_cond == $past(inst_ext[5:0]))
		else $error("condition not taken from following word");
	chk_set_ea: assert property (take && inst_op[15:12] == CPSR_LINE_CODE &&
		op_type == CPSR_TYPE_COND && trap_operand_form == CPSR_EA_AREG
		|=> exc_req && exc_vector == CPSR_VEC_ILLEGAL)
		else $error("set with address register not refused");
	chk_trap_true: assert property (resp && op_reg == CPSR_OP_TRAP && cp_resp_true
		|=> exc_req && exc_vector == CPSR_VEC_CPTRAP && !inst_done)
		else $error("true trap condition did not trap");
	chk_trap_false: assert property (resp && op_reg == CPSR_OP_TRAP && !cp_resp_true
		|=> inst_done && !exc_req && !dest_wr)
		else $error("false trap condition did not continue");
	chk_trap_len: assert property (take && dec_op == CPSR_OP_TRAP && dec_legal
		|=> next_pc == $past(inst_pc) + CPSR_BASE_BYTES + {29'h0, $past(trap_words), 1'b0})
		else $error("trap length accounting wrong");
	chk_form_bad: assert property (take && inst_op[15:12] == CPSR_LINE_CODE &&
		op_type == CPSR_TYPE_COND && trap_operand_form == CPSR_EA_EXT && op_rg > CPSR_FORM_NONE
		|=> exc_req && exc_vector == CPSR_VEC_ILLEGAL)
		else $error("undefined operand form not refused");

	cov_save_done: cover property (last_beat && op_reg == CPSR_OP_SAVE ##1 inst_done);
	cov_come_again: cover property (resp && op_reg == CPSR_OP_RESTORE && cp_resp_again);
	cov_trap_taken: cover property (resp && op_reg == CPSR_OP_TRAP && cp_resp_true);
	cov_set_true: cover property (resp && op_reg == CPSR_OP_SET && cp_resp_true);
endmodule

`default_nettype wire

/* hdl/cpsr_pkg.sv */
`default_nettype none

package cpsr_pkg;
	// Operation word: line code, selector, type, mode, register
	localparam logic [3:0] CPSR_LINE_CODE  = 4'hf;
	localparam logic [2:0] CPSR_TYPE_COND  = 3'h1;
	localparam logic [2:0] CPSR_TYPE_SAVE  = 3'h4;
	localparam logic [2:0] CPSR_TYPE_REST  = 3'h5;
	localparam int         CPSR_SEL_LSB    = 9;
	localparam int         CPSR_TYPE_LSB   = 6;
	localparam int         CPSR_MODE_LSB   = 3;
	localparam int         CPSR_COND_WIDTH = 6;

	// Effective address modes
	localparam logic [2:0] CPSR_EA_DREG  = 3'h0;
	localparam logic [2:0] CPSR_EA_AREG  = 3'h1;
	localparam logic [2:0] CPSR_EA_IND   = 3'h2;
	localparam logic [2:0] CPSR_EA_POST  = 3'h3;
	localparam logic [2:0] CPSR_EA_PRE   = 3'h4;
	localparam logic [2:0] CPSR_EA_DISP  = 3'h5;
	localparam logic [2:0] CPSR_EA_IDX   = 3'h6;
	localparam logic [2:0] CPSR_EA_EXT   = 3'h7;
	localparam logic [2:0] CPSR_EXT_ABSW = 3'h0;
	localparam logic [2:0] CPSR_EXT_ABSL = 3'h1;

	// Trap operand forms
	localparam logic [2:0] CPSR_FORM_ONE  = 3'h2;
	localparam logic [2:0] CPSR_FORM_TWO  = 3'h3;
	localparam logic [2:0] CPSR_FORM_NONE = 3'h4;

	// Operation word plus condition word, in bytes
	localparam logic [31:0] CPSR_BASE_BYTES = 32'h4;

	// Exception vectors, plain defaults
	localparam logic [7:0] CPSR_VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] CPSR_VEC_PRIV    = 8'h08;
	localparam logic [7:0] CPSR_VEC_CPTRAP  = 8'h07;
	localparam logic [7:0] CPSR_VEC_UNIMPL  = 8'h0b;

	localparam logic [7:0]  CPSR_COUNT_RST = 8'h00;
	localparam logic [31:0] CPSR_WORD_RST  = 32'h0;

	typedef enum logic [1:0] {
		CPSR_OP_RESTORE = 2'h0,
		CPSR_OP_SAVE    = 2'h1,
		CPSR_OP_SET     = 2'h2,
		CPSR_OP_TRAP    = 2'h3
	} cpsr_op_e;

	typedef enum logic [2:0] {
		CPSR_ST_IDLE = 3'b001,
		CPSR_ST_WAIT = 3'b010,
		CPSR_ST_XFER = 3'b100
	} cpsr_state_e;
endpackage

`default_nettype wire

/* bench/cpsr_cp_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cpsr_cp_model
	import cpsr_pkg::*;
(
	input  wire logic        clk_sys,        // System clock
	input  wire logic        reset_n,        // Reset, active low
	input  wire logic        cp_req,         // Command pulse
	input  wire cpsr_op_e    cp_op,          // Kind of command
	input  wire logic [5:0]  cp_cond,        // Condition to evaluate
	input  wire logic        cp_rd_ready,    // Decoder takes save words
	input  wire logic [1:0]  resp_delay,     // Idle cycles before a directive
	input  wire logic [7:0]  xfer_len,       // State words to announce
	input  wire logic        again_en,       // Come again once per restore
	input  wire logic        word_stall,     // Withhold next save word
	output logic             cp_resp_valid,  // Directive pulse
	output logic             cp_resp_true,   // Condition result
	output logic             cp_resp_again,  // Come again
	output logic [7:0]       cp_resp_len,    // Words to move
	output logic             cp_word_valid,  // Save word offered
	output logic [31:0]      cp_word_data    // Save word
);
	logic        pend_reg;
	logic [1:0]  wait_reg;
	logic        again_reg;
	logic [7:0]  idx_reg;
	logic        again_now;
	logic [31:0] word_val;

	assign again_now = again_en && (cp_op == CPSR_OP_RESTORE) && !again_reg;
	assign word_val = 32'hc0de0000 + {24'h0, idx_reg};
	// Off-beat lines show the inverse so a stale word cannot pass for a fresh one
	assign cp_word_data = cp_word_valid ? word_val : ~word_val;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{pend_reg, wait_reg, again_reg, cp_resp_valid} <= 5'h00;
			{cp_resp_true, cp_resp_again, cp_resp_len} <= 10'h000;
		end else begin
			cp_resp_valid <= 1'b0;
			{cp_resp_true, cp_resp_again, cp_resp_len} <= ~{cp_resp_true, cp_resp_again, cp_resp_len};
			if (cp_req) begin
				pend_reg <= 1'b1;
				wait_reg <= resp_delay;
			end else if (pend_reg && wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
			end else if (pend_reg) begin
				pend_reg <= 1'b0;
				cp_resp_valid <= 1'b1;
				cp_resp_true <= ^cp_cond;
				cp_resp_again <= again_now;
				again_reg <= again_now;
				cp_resp_len <= xfer_len;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cp_word_valid <= 1'b0;
			idx_reg <= 8'h00;
		end else begin
			if (!cp_word_valid || cp_rd_ready) cp_word_valid <= !word_stall;
			if (cp_req) idx_reg <= 8'h00;
			else if (cp_word_valid && cp_rd_ready) idx_reg <= idx_reg + 8'h01;
		end
	end
endmodule

`default_nettype wire

/* bench/coproc_save_restore_cond_decode_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end

module coproc_save_restore_cond_decode_tb_top
	import cpsr_pkg::*;
;
	logic        clk_sys, reset_n, inst_valid, supervisor, inst_ready, cp_req, cp_resp_valid;
	logic        cp_resp_true, cp_resp_again, cp_wr_valid, cp_word_valid, cp_rd_ready;
	logic        mem_rd_req, mem_rd_valid, mem_wr_valid, dest_wr, exc_req, inst_done;
	logic        irq_inhibit, again_en, word_stall;
	logic [15:0] inst_op, inst_ext, op;
	logic [31:0] inst_pc, cp_wr_data, cp_word_data, mem_rd_data, mem_wr_data, next_pc, mem_idx, r;
	logic [7:0]  cp_resp_len, dest_byte, exc_vector, xfer_len;
	logic [5:0]  cp_cond;
	logic [2:0]  cp_sel, ea_mode, ea_reg;
	logic [1:0]  resp_delay;
	cpsr_op_e    cp_op;
	int          err_total, cmp_count, i;
	int          cnt [7];  // Pulses seen: req, wr, mw, dest, exc, done, inhibit
	localparam logic [2:0] TYPES [3] = '{CPSR_TYPE_REST, CPSR_TYPE_SAVE, CPSR_TYPE_COND};

	cpsr_decode dut_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .inst_valid(inst_valid), .inst_op(inst_op),
		.inst_ext(inst_ext), .inst_pc(inst_pc), .supervisor(supervisor), .inst_ready(inst_ready),
		.cp_req(cp_req), .cp_op(cp_op), .cp_sel(cp_sel), .cp_cond(cp_cond),
		.cp_resp_valid(cp_resp_valid), .cp_resp_true(cp_resp_true),
		.cp_resp_again(cp_resp_again), .cp_resp_len(cp_resp_len), .cp_wr_valid(cp_wr_valid),
		.cp_wr_data(cp_wr_data), .cp_word_valid(cp_word_valid), .cp_word_data(cp_word_data),
		.cp_rd_ready(cp_rd_ready), .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
		.ea_mode(ea_mode), .ea_reg(ea_reg), .dest_wr(dest_wr), .dest_byte(dest_byte),
		.exc_req(exc_req), .exc_vector(exc_vector), .next_pc(next_pc), .inst_done(inst_done),
		.irq_inhibit(irq_inhibit)
	);

	cpsr_cp_model cp_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .cp_req(cp_req), .cp_op(cp_op), .cp_cond(cp_cond),
		.cp_rd_ready(cp_rd_ready), .resp_delay(resp_delay), .xfer_len(xfer_len),
		.again_en(again_en), .word_stall(word_stall), .cp_resp_valid(cp_resp_valid),
		.cp_resp_true(cp_resp_true), .cp_resp_again(cp_resp_again), .cp_resp_len(cp_resp_len),
		.cp_word_valid(cp_word_valid), .cp_word_data(cp_word_data)
	);

	assign mem_rd_data = mem_rd_valid ? 32'h5a000000 + mem_idx : ~(32'h5a000000 + mem_idx);

	function automatic logic [7:0] exp_vec(input logic [15:0] w, input logic sup);
		logic [2:0] m;
		logic       abs_ok;
		m = w[5:3];
		abs_ok = (m == 3'h7) && (w[2:0] <= 3'h1);
		if (w[15:12] != CPSR_LINE_CODE) return CPSR_VEC_UNIMPL;
		case (w[8:6])
			CPSR_TYPE_REST: begin
				if (!sup) return CPSR_VEC_PRIV;
				return (abs_ok || m inside {3'h2, 3'h3, 3'h6}) ? 8'h00 : CPSR_VEC_ILLEGAL;
			end
			CPSR_TYPE_SAVE: return (abs_ok || m inside {3'h2, 3'h4, 3'h5, 3'h6}) ?
				8'h00 : CPSR_VEC_ILLEGAL;
			CPSR_TYPE_COND: return (m == 3'h1 || (m == 3'h7 && w[2:0] >= 3'h5)) ?
				CPSR_VEC_ILLEGAL : 8'h00;
			default: return CPSR_VEC_UNIMPL;
		endcase
	endfunction

	function automatic cpsr_op_e exp_kind(input logic [15:0] w);
		if (w[8:6] == CPSR_TYPE_REST) return CPSR_OP_RESTORE;
		if (w[8:6] == CPSR_TYPE_SAVE) return CPSR_OP_SAVE;
		if (w[5:3] == 3'h7 && w[2:0] inside {3'h2, 3'h3, 3'h4}) return CPSR_OP_TRAP;
		return CPSR_OP_SET;
	endfunction

	task automatic results();
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Called at a falling edge with the decoder idle
	task automatic run_one(input logic [15:0] op_w, input logic [15:0] ext_w, input logic sup);
		logic [7:0]  vec;
		cpsr_op_e    kind;
		logic        tr;
		int          k;
		logic [31:0] opnd;
		vec = exp_vec(op_w, sup);
		kind = exp_kind(op_w);
		tr = ^ext_w[5:0];
		// Trailing operand bytes that the trap form asks to step over
		opnd = op_w[2:0] == CPSR_FORM_ONE ? 32'h2 : op_w[2:0] == CPSR_FORM_TWO ? 32'h4 : 32'h0;
		cnt = '{default: 0};
		mem_idx = 32'h0;
		{inst_valid, inst_op, inst_ext, supervisor} = {1'b1, op_w, ext_w, sup};
		inst_pc = $urandom & 32'hfffffffe;
		xfer_len = 8'($urandom_range(3));
		resp_delay = 2'($urandom_range(3));
		again_en = 1'($urandom_range(1));
		@(negedge clk_sys);
		{inst_valid, inst_op, inst_ext} = {1'b0, ~op_w, ~ext_w};
		for (k = 0; k < 200 && cnt[4] + cnt[5] == 0; k++) @(negedge clk_sys);
		// One more cycle so a lingering interrupt hold is not charged to the next one
		@(negedge clk_sys);
		`CHK(k < 200, 1'b1)
		`CHK(cnt[4] != 0, vec != 8'h00 || (kind == CPSR_OP_TRAP && tr))
		if (vec != 8'h00) begin
			`CHK(exc_vector, vec)
			`CHK(cnt[0], 0)
		end else begin
			`CHK({cp_sel, ea_mode, ea_reg}, {op_w[11:9], op_w[5:0]})
			`CHK(cp_op, kind)
			`CHK(cp_cond, kind inside {CPSR_OP_SET, CPSR_OP_TRAP} ? ext_w[5:0] : 6'h00)
			case (kind)
				CPSR_OP_SET: `CHK({cnt[3], dest_byte}, {32'd1, tr ? 8'hff : 8'h00})
				CPSR_OP_SAVE: `CHK(cnt[2], 32'(xfer_len))
				CPSR_OP_RESTORE: begin
					`CHK(cnt[1], 32'(xfer_len))
					`CHK({cnt[0], cnt[6] != 0}, {32'd1 + again_en, again_en})
				end
				default: begin
					`CHK(next_pc, inst_pc + CPSR_BASE_BYTES + opnd)
					if (tr) `CHK(exc_vector, CPSR_VEC_CPTRAP)
					else `CHK(cnt[5], 1)
				end
			endcase
		end
	endtask

	// Memory offers a word only while the decoder asks, so every offer is taken at the next edge
	always @(negedge clk_sys) begin
		word_stall <= ($urandom_range(3) == 0);
		mem_rd_valid <= (mem_rd_req === 1'b1) && ($urandom_range(3) != 0);
	end

	// Sampled just after the edge so a pulse is seen once, never racing the edge that launches it
	always @(posedge clk_sys) begin
		#1;
		if (reset_n) begin
			cnt[0] += (cp_req === 1'b1);
			if (cp_wr_valid === 1'b1) begin
				`CHK(cp_wr_data, 32'h5a000000 + cnt[1])
				cnt[1]++;
				mem_idx = mem_idx + 32'h1;
			end
			if (mem_wr_valid === 1'b1) begin
				`CHK(mem_wr_data, 32'hc0de0000 + cnt[2])
				cnt[2]++;
			end
			cnt[3] += (dest_wr === 1'b1);
			cnt[4] += (exc_req === 1'b1);
			cnt[5] += (inst_done === 1'b1);
			cnt[6] += (irq_inhibit === 1'b1);
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial begin
		#3000000;
		err_total++;
		results();
	end

	initial begin
		{reset_n, inst_valid, supervisor, again_en} = 4'h0;
		{inst_op, inst_ext, inst_pc, mem_idx, xfer_len, resp_delay} = '0;
		{err_total, cmp_count} = '0;
		cnt = '{default: 0};
		void'($urandom(9));
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		for (i = 0; i < 500; i++) begin
			if (i == 400) begin
				reset_n = 1'b0;
				@(negedge clk_sys);
			end
			if (i == 0 || i == 400) begin
				`CHK({inst_ready, cp_req, exc_req, dest_wr, next_pc}, {4'h8, 32'h0})
				reset_n = 1'b1;
			end
			r = $urandom;
			op = r[15:0];
			// First pass walks every mode and register for each instruction type
			if (i < 192) op[8:0] = {TYPES[i / 64], 6'(i % 64)};
			else if (r[31:29] != 3'h0) op[8:6] = TYPES[r[28:27] % 2'h3];
			if (i < 192 || r[26:24] != 3'h0) op[15:12] = CPSR_LINE_CODE;
			run_one(op, 16'($urandom), i < 192 || r[23:22] != 2'h0);
		end
		results();
	end
endmodule

`default_nettype wire
